/* File: core/bus_holder.sv */
// Shared constants for the parallel-port address pin multiplexer, and the
// bus holder that keeps undriven address pins at their last level.
// Assumes one clock, mclk, and an active-low asynchronous reset, rst_n.
package pin_mux_pkg;
	localparam int ADDR_PINS = 20;
	localparam int UPPER_PINS = 4;
	localparam int LOWER_PINS = 16;
	localparam int UPPER_LSB = 16;
	localparam int HOST_ADDR_W = 16;
	localparam int HOST_DATA_W = 16;
	localparam int CLK_OUTS = 2;

	localparam logic [7:0] OFF_EXT_BUS_CTRL = 8'h00;
	localparam logic [7:0] OFF_MEM_GCTRL_1 = 8'h04;
	localparam logic [7:0] OFF_MEM_GCTRL_2 = 8'h08;
	localparam logic [7:0] OFF_GPIO_DIR = 8'h0c;
	localparam logic [7:0] OFF_GPIO_OUT = 8'h10;
	localparam logic [7:0] OFF_GPIO_IN = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_MEM_ADDR = 8'h1c;
	localparam logic [7:0] OFF_HOST_ADDR = 8'h20;

	localparam int BIT_HOLDER_EN = 0;
	localparam int BIT_CLK_HZ = 0;
	localparam int BIT_ST_ALT = 0;
	localparam int BIT_ST_MEM = 1;
	localparam int BIT_ST_HOLD = 2;
	localparam int BIT_ST_OFF = 3;

	localparam logic RST_HOLDER_EN = 1'b1;
	localparam logic RST_CLK_HZ = 1'b0;
	localparam logic [UPPER_PINS-1:0] RST_GPIO_DIR = 4'h0;
	localparam logic [UPPER_PINS-1:0] RST_GPIO_OUT = 4'h0;
	localparam logic [ADDR_PINS-1:0] RST_MEM_ADDR = 20'h00000;

	typedef enum logic [2:0] {
		FUNC_UNSET = 3'b001,
		FUNC_ALT = 3'b010,
		FUNC_MEM = 3'b100
	} func_t;
endpackage

`timescale 1ns/1ps

module bus_holder import pin_mux_pkg::*; #(
	parameter int W = ADDR_PINS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [W-1:0] devOe,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] holdOut,
	output logic [W-1:0] holdOe
);
	typedef struct packed {
		logic [W-1:0] level;
		logic [W-1:0] oe;
	} holder_t;

	holder_t st_reg;
	holder_t st_next;

	// Each bit follows the pin level and, while enabled, drives it back whenever the device does not.
	// The device enable seen here is its next value, so the keeper takes over on the same edge with no gap.
	always_comb begin
		st_next = st_reg;
		for (int i = 0; i < W; i++) begin
			st_next.level[i] = pinIn[i];
			st_next.oe[i] = en & ~devOe[i];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign holdOut = st_reg.level;
	assign holdOe = st_reg.oe;

	property p_holder_follows;
		@(posedge mclk) disable iff (!rst_n)
		(en && devOe == '0) |=> (holdOe == '1 && holdOut == $past(pinIn));
	endproperty
	a_holder_follows: assert property (p_holder_follows) else $error("Holder did not keep undriven pins.");
endmodule

/* File: core/parallel_address_pin_mux.sv */
// Strap-selected function multiplexer for the parallel-port address pins.
// Assumes an APB master on mclk, synchronous pin inputs and an external pin resolver.
// How it works
// - Strap low: upper four pins are general I/O; high: memory address 21 to 18.
// - Strap low: pins 17 to 2 are host address; high: memory address 17 to 2.
// - Function is taken when reset rises and never changes afterwards.
// - Bus holders keep tri-stated pins at their last driven level while enabled.
// - Holders come up enabled; software switches them via the bus control register.
// - In general I/O function the four pins start as inputs.
// - Memory address pins float during reset, then drive zero.
// - In host function the sixteen host address pins are inputs.
// - Strap low selects non-multiplexed host mode, separate 16-bit address and data.
// - Each non-multiplexed host cycle carries one 16-bit data word.
// - All address pins float while a hold request is granted.
// - In hold, each memory clock keeps toggling unless its tristate bit is set.
// - Address pins float in off mode: test reset 0, emulation 0 high, off pin low.
// - Address pins float while reset is low, whatever the function.
// - Each general I/O pin can be set to input or output.
`timescale 1ns/1ps

module parallel_address_pin_mux import pin_mux_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic portFunctionStrap,
	input wire logic holdReqN,
	output logic holdAckN,
	input wire logic testResetN,
	input wire logic emulationPin0,
	input wire logic emulationOffPin,
	input wire logic [ADDR_PINS-1:0] addrIn,
	output logic [ADDR_PINS-1:0] addrOut,
	output logic [ADDR_PINS-1:0] addrOe,
	output logic [ADDR_PINS-1:0] addrHoldOut,
	output logic [ADDR_PINS-1:0] addrHoldOe,
	output logic [CLK_OUTS-1:0] memoryClockOut,
	output logic [CLK_OUTS-1:0] memoryClockOe,
	output logic hostMode,
	output logic [HOST_ADDR_W-1:0] hostAddressIn,
	input wire logic [HOST_DATA_W-1:0] hostDataIn,
	output logic [HOST_DATA_W-1:0] hostDataWord,
	input wire logic hostCycle,
	output logic hostWordValid
);
	typedef struct packed {
		func_t funcMode;
		logic holderEn;
		logic [CLK_OUTS-1:0] clkHz;
		logic [UPPER_PINS-1:0] gpioDir;
		logic [UPPER_PINS-1:0] gpioOut;
		logic [UPPER_PINS-1:0] gpioIn;
		logic [ADDR_PINS-1:0] memAddr;
		logic [HOST_ADDR_W-1:0] hostAddr;
		logic [HOST_DATA_W-1:0] hostData;
		logic hostValid;
		logic hostModeR;
		logic [ADDR_PINS-1:0] pinOut;
		logic [ADDR_PINS-1:0] pinOe;
		logic memClk;
		logic [CLK_OUTS-1:0] memClkOe;
		logic holdAck;
		logic holdAckOutN;
		logic offSeen;
		logic ready;
		logic err;
		logic [31:0] rdata;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic offMode;
	logic holdNext;
	logic driveNext;
	logic setup;
	logic access;

	// Tells whether an APB byte address hits one of the block's registers.
	function automatic logic isMapped(input logic [31:0] a);
		logic hit;
		hit = 1'b0;
		if (a[31:8] == 24'h000000) begin
			case (a[7:0])
				OFF_EXT_BUS_CTRL, OFF_MEM_GCTRL_1, OFF_MEM_GCTRL_2, OFF_GPIO_DIR, OFF_GPIO_OUT,
				OFF_GPIO_IN, OFF_STATUS, OFF_MEM_ADDR, OFF_HOST_ADDR: begin
					hit = 1'b1;
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end
		return hit;
	endfunction

	// Produces the read value of a register from the current state.
	function automatic logic [31:0] readValue(input logic [7:0] off, input state_t s);
		logic [31:0] v;
		v = 32'h00000000;
		case (off)
			OFF_EXT_BUS_CTRL: begin
				v[BIT_HOLDER_EN] = s.holderEn;
			end
			OFF_MEM_GCTRL_1: begin
				v[BIT_CLK_HZ] = s.clkHz[0];
			end
			OFF_MEM_GCTRL_2: begin
				v[BIT_CLK_HZ] = s.clkHz[1];
			end
			OFF_GPIO_DIR: begin
				v[UPPER_PINS-1:0] = s.gpioDir;
			end
			OFF_GPIO_OUT: begin
				v[UPPER_PINS-1:0] = s.gpioOut;
			end
			OFF_GPIO_IN: begin
				v[UPPER_PINS-1:0] = s.gpioIn;
			end
			OFF_STATUS: begin
				v[BIT_ST_ALT] = (s.funcMode == FUNC_ALT);
				v[BIT_ST_MEM] = (s.funcMode == FUNC_MEM);
				v[BIT_ST_HOLD] = s.holdAck;
				v[BIT_ST_OFF] = s.offSeen;
			end
			OFF_MEM_ADDR: begin
				v[ADDR_PINS-1:0] = s.memAddr;
			end
			OFF_HOST_ADDR: begin
				v[HOST_ADDR_W-1:0] = s.hostAddr;
			end
			default: begin
				v = 32'h00000000;
			end
		endcase
		return v;
	endfunction

	assign offMode = ~testResetN & emulationPin0 & ~emulationOffPin;
	assign holdNext = ~holdReqN;
	assign setup = psel & ~penable;
	assign access = psel & penable & st_reg.ready;

	always_comb begin
		st_next = st_reg;
		driveNext = (st_reg.funcMode != FUNC_UNSET) & ~holdNext & ~offMode;

		// The strap is caught once, on the first edge after reset is released.
		case (st_reg.funcMode)
			FUNC_UNSET: begin
				st_next.funcMode = portFunctionStrap ? FUNC_MEM : FUNC_ALT;
			end
			FUNC_ALT, FUNC_MEM: begin
				st_next.funcMode = st_reg.funcMode;
			end
			default: begin
				st_next.funcMode = FUNC_UNSET;
			end
		endcase

		st_next.holdAck = holdNext;
		st_next.holdAckOutN = ~holdNext;
		st_next.offSeen = offMode;
		st_next.hostModeR = (st_reg.funcMode == FUNC_ALT);
		st_next.gpioIn = addrIn[UPPER_LSB +: UPPER_PINS];

		// Host address and data are separate buses; one word per host cycle.
		if (st_reg.funcMode == FUNC_ALT) begin
			st_next.hostAddr = addrIn[LOWER_PINS-1:0];
			st_next.hostValid = hostCycle;
			if (hostCycle) begin
				st_next.hostData = hostDataIn;
			end
		end else begin
			st_next.hostValid = 1'b0;
		end

		// Pin drive per function; nothing drives before the function is known.
		st_next.pinOe = '0;
		st_next.pinOut = '0;
		case (st_reg.funcMode)
			FUNC_ALT: begin
				st_next.pinOut[UPPER_LSB +: UPPER_PINS] = st_reg.gpioOut;
				st_next.pinOe[UPPER_LSB +: UPPER_PINS] = driveNext ? st_reg.gpioDir : '0;
				st_next.pinOe[LOWER_PINS-1:0] = '0;
			end
			FUNC_MEM: begin
				st_next.pinOut = st_reg.memAddr;
				st_next.pinOe = driveNext ? '1 : '0;
			end
			default: begin
				st_next.pinOe = '0;
			end
		endcase

		// Memory clocks run once configured and float in hold only when asked.
		st_next.memClk = (st_reg.funcMode != FUNC_UNSET) ? ~st_reg.memClk : 1'b0;
		for (int i = 0; i < CLK_OUTS; i++) begin
			st_next.memClkOe[i] = (st_reg.funcMode != FUNC_UNSET) & ~offMode & ~(holdNext & st_reg.clkHz[i]);
		end

		// APB slave: data prepared in setup, pready high in the access cycle.
		st_next.ready = 1'b0;
		st_next.err = 1'b0;
		if (setup) begin
			st_next.ready = 1'b1;
			st_next.err = ~isMapped(paddr);
			st_next.rdata = (isMapped(paddr) && !pwrite) ? readValue(paddr[7:0], st_reg) : 32'h00000000;
		end
		if (access && pwrite && isMapped(paddr)) begin
			case (paddr[7:0])
				OFF_EXT_BUS_CTRL: begin
					st_next.holderEn = pwdata[BIT_HOLDER_EN];
				end
				OFF_MEM_GCTRL_1: begin
					st_next.clkHz[0] = pwdata[BIT_CLK_HZ];
				end
				OFF_MEM_GCTRL_2: begin
					st_next.clkHz[1] = pwdata[BIT_CLK_HZ];
				end
				OFF_GPIO_DIR: begin
					st_next.gpioDir = pwdata[UPPER_PINS-1:0];
				end
				OFF_GPIO_OUT: begin
					st_next.gpioOut = pwdata[UPPER_PINS-1:0];
				end
				OFF_MEM_ADDR: begin
					st_next.memAddr = pwdata[ADDR_PINS-1:0];
				end
				default: begin
					st_next.memAddr = st_reg.memAddr;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.funcMode <= FUNC_UNSET;
			st_reg.holderEn <= RST_HOLDER_EN;
			st_reg.clkHz <= {CLK_OUTS{RST_CLK_HZ}};
			st_reg.gpioDir <= RST_GPIO_DIR;
			st_reg.gpioOut <= RST_GPIO_OUT;
			st_reg.gpioIn <= '0;
			st_reg.memAddr <= RST_MEM_ADDR;
			st_reg.hostAddr <= '0;
			st_reg.hostData <= '0;
			st_reg.hostValid <= 1'b0;
			st_reg.hostModeR <= 1'b0;
			st_reg.pinOut <= '0;
			st_reg.pinOe <= '0;
			st_reg.memClk <= 1'b0;
			st_reg.memClkOe <= '0;
			st_reg.holdAck <= 1'b0;
			st_reg.holdAckOutN <= 1'b1;
			st_reg.offSeen <= 1'b0;
			st_reg.ready <= 1'b0;
			st_reg.err <= 1'b0;
			st_reg.rdata <= 32'h00000000;
		end else begin
			st_reg <= st_next;
		end
	end

	bus_holder #(
		.W(ADDR_PINS)
	) u_holder (
		.mclk(mclk),
		.rst_n(rst_n),
		.en(st_reg.holderEn),
		.devOe(st_next.pinOe),
		.pinIn(addrIn),
		.holdOut(addrHoldOut),
		.holdOe(addrHoldOe)
	);

	assign prdata = st_reg.rdata;
	assign pready = st_reg.ready;
	assign pslverr = st_reg.err;
	assign holdAckN = st_reg.holdAckOutN;
	assign addrOut = st_reg.pinOut;
	assign addrOe = st_reg.pinOe;
	assign memoryClockOut = {CLK_OUTS{st_reg.memClk}};
	assign memoryClockOe = st_reg.memClkOe;
	assign hostMode = st_reg.hostModeR;
	assign hostAddressIn = st_reg.hostAddr;
	assign hostDataWord = st_reg.hostData;
	assign hostWordValid = st_reg.hostValid;

	property p_unset_floats;
		@(posedge mclk) disable iff (!rst_n)
		(st_reg.funcMode == FUNC_UNSET) |-> (addrOe == '0 && memoryClockOe == '0);
	endproperty
	a_unset_floats: assert property (p_unset_floats) else $error("Pins driven before function known.");

	property p_func_fixed;
		@(posedge mclk) disable iff (!rst_n)
		(st_reg.funcMode != FUNC_UNSET) |=> $stable(st_reg.funcMode);
	endproperty
	a_func_fixed: assert property (p_func_fixed) else $error("Pin function changed after reset.");

	property p_strap_taken;
		@(posedge mclk) disable iff (!rst_n)
		(st_reg.funcMode == FUNC_UNSET) |=> (st_reg.funcMode == ($past(portFunctionStrap) ? FUNC_MEM : FUNC_ALT));
	endproperty
	a_strap_taken: assert property (p_strap_taken) else $error("Strap level not applied.");

	property p_host_inputs;
		@(posedge mclk) disable iff (!rst_n)
		(st_reg.funcMode == FUNC_ALT) |-> (addrOe[LOWER_PINS-1:0] == '0);
	endproperty
	a_host_inputs: assert property (p_host_inputs) else $error("Host address pins driven.");

	property p_gpio_dir;
		@(posedge mclk) disable iff (!rst_n)
		(st_reg.funcMode == FUNC_ALT && $past(st_reg.funcMode) == FUNC_ALT)
			|-> ((addrOe[UPPER_LSB +: UPPER_PINS] & ~$past(st_reg.gpioDir)) == '0);
	endproperty
	a_gpio_dir: assert property (p_gpio_dir) else $error("Input general pin driven.");

	property p_gpio_start_input;
		@(posedge mclk) disable iff (!rst_n)
		($past(st_reg.funcMode) == FUNC_UNSET && st_reg.funcMode == FUNC_ALT) |-> (st_reg.gpioDir == RST_GPIO_DIR);
	endproperty
	a_gpio_start_input: assert property (p_gpio_start_input) else $error("General pins not inputs after reset.");

	property p_mem_drive;
		@(posedge mclk) disable iff (!rst_n)
		(st_reg.funcMode == FUNC_MEM && holdReqN && !offMode) |=> (addrOe == '1 && addrOut == $past(st_reg.memAddr));
	endproperty
	a_mem_drive: assert property (p_mem_drive) else $error("Memory address not driven.");

	property p_hold_float;
		@(posedge mclk) disable iff (!rst_n)
		(!holdReqN) |=> (addrOe == '0 && !holdAckN);
	endproperty
	a_hold_float: assert property (p_hold_float) else $error("Address pins driven in hold.");

	property p_off_float;
		@(posedge mclk) disable iff (!rst_n)
		offMode |=> (addrOe == '0 && memoryClockOe == '0);
	endproperty
	a_off_float: assert property (p_off_float) else $error("Pins driven in off mode.");

	property p_hold_clock;
		@(posedge mclk) disable iff (!rst_n)
		(!holdReqN && !st_reg.clkHz[0] && st_reg.funcMode != FUNC_UNSET && !offMode)
			|=> (memoryClockOe[0] && memoryClockOut[0] != $past(memoryClockOut[0]));
	endproperty
	a_hold_clock: assert property (p_hold_clock) else $error("Memory clock stopped in hold.");

	property p_hold_clock_hz;
		@(posedge mclk) disable iff (!rst_n)
		(!holdReqN && st_reg.clkHz[1]) |=> !memoryClockOe[1];
	endproperty
	a_hold_clock_hz: assert property (p_hold_clock_hz) else $error("Memory clock not floated in hold.");

	property p_host_addr;
		@(posedge mclk) disable iff (!rst_n)
		(st_reg.funcMode == FUNC_ALT) |=> (hostAddressIn == $past(addrIn[LOWER_PINS-1:0]) && hostMode);
	endproperty
	a_host_addr: assert property (p_host_addr) else $error("Host address not captured.");

	property p_host_word;
		@(posedge mclk) disable iff (!rst_n)
		(st_reg.funcMode == FUNC_ALT && hostCycle) |=> (hostWordValid && hostDataWord == $past(hostDataIn));
	endproperty
	a_host_word: assert property (p_host_word) else $error("Host word not taken.");

	property p_holder_write;
		@(posedge mclk) disable iff (!rst_n)
		(access && pwrite && paddr == {24'h000000, OFF_EXT_BUS_CTRL})
			|=> (st_reg.holderEn == $past(pwdata[BIT_HOLDER_EN]));
	endproperty
	a_holder_write: assert property (p_holder_write) else $error("Holder enable not written.");
endmodule

/* File: tb/parallel_address_pin_mux_tb.sv */
// Self-checking bench for the parallel-port address pin multiplexer.
// Assumes the pin partner model resolves the address pin levels.
`timescale 1ns/1ps

module parallel_address_pin_mux_tb import pin_mux_pkg::*;;
	logic mclk = 1'b0;
	logic rstN = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic strap = 1'b1, holdReqN = 1'b1, holdAckN, testResetN = 1'b1, emulation_pin_0 = 1'b0, offPin = 1'b1;
	logic hostCycle = 1'b0, hostMode, wordValid;
	logic [ADDR_PINS-1:0] addrIn, addrOut, addrOe, keepOut, keepOe, extOut = '0, extOe = '0;
	logic [CLK_OUTS-1:0] clkOut, clkOe;
	logic [15:0] hostAddr, hostData = 16'h0, hostWord;
	int fails = 0, comparisons = 0;

	always #20 mclk = ~mclk;

	parallel_address_pin_mux u_dut (.mclk(mclk), .rst_n(rstN), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portFunctionStrap(strap), .holdReqN(holdReqN), .holdAckN(holdAckN), .testResetN(testResetN),
		.emulationPin0(emulation_pin_0), .emulationOffPin(offPin), .addrIn(addrIn), .addrOut(addrOut), .addrOe(addrOe),
		.addrHoldOut(keepOut), .addrHoldOe(keepOe), .memoryClockOut(clkOut), .memoryClockOe(clkOe),
		.hostMode(hostMode), .hostAddressIn(hostAddr), .hostDataIn(hostData), .hostDataWord(hostWord),
		.hostCycle(hostCycle), .hostWordValid(wordValid));

	pin_partner u_partner (.mclk(mclk), .devOut(addrOut), .devOe(addrOe), .keepOut(keepOut), .keepOe(keepOe),
		.extOut(extOut), .extOe(extOe), .pinLevel(addrIn));

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task reset_dut(input logic s);
		@(posedge mclk);
		strap <= s;
		extOe <= '0;
		@(posedge mclk);
		rstN <= 1'b0;
		repeat (19) @(posedge mclk);
		@(negedge mclk);
		chk("pins in reset", 32'h0, addrOe);
		@(posedge mclk);
		rstN <= 1'b1;
		repeat (3) @(negedge mclk);
	endtask

	task test_memory;
		logic c;
		reset_dut(1'b1);
		chk("oe after reset", 32'hfffff, addrOe);
		chk("value after reset", 32'h0, addrOut);
		@(posedge mclk);
		strap <= 1'b0;
		apb(1'b1, {24'h0, OFF_MEM_ADDR}, 32'h5a5a5);
		apb(1'b1, {24'h0, OFF_MEM_GCTRL_2}, 32'h1);
		apb(1'b0, {24'h0, OFF_STATUS}, 32'h0);
		chk("status", 32'h2, rd);
		repeat (2) @(negedge mclk);
		chk("memory address", 32'h5a5a5, addrOut);
		@(posedge mclk);
		holdReqN <= 1'b0;
		repeat (2) @(negedge mclk);
		chk("hold oe", 32'h0, addrOe);
		chk("hold ack", 32'h0, holdAckN);
		chk("held level", 32'h5a5a5, addrIn);
		chk("keeper level", 32'h5a5a5, keepOut);
		chk("keeper on", 32'hfffff, keepOe);
		chk("clock oe", 32'h1, clkOe);
		c = clkOut[0];
		@(negedge mclk);
		chk("clock toggles", {31'h0, ~c}, clkOut[0]);
		apb(1'b0, {24'h0, OFF_STATUS}, 32'h0);
		chk("hold status", 32'h6, rd);
		apb(1'b1, {24'h0, OFF_EXT_BUS_CTRL}, 32'h0);
		repeat (2) @(negedge mclk);
		chk("holder off", 32'h0, keepOe);
		@(posedge mclk);
		holdReqN <= 1'b1;
		testResetN <= 1'b0;
		emulation_pin_0 <= 1'b1;
		offPin <= 1'b0;
		repeat (2) @(negedge mclk);
		chk("off mode oe", 32'h0, addrOe);
		@(posedge mclk);
		testResetN <= 1'b1;
		emulation_pin_0 <= 1'b0;
		offPin <= 1'b1;
		repeat (2) @(negedge mclk);
		chk("drive resumes", 32'hfffff, addrOe);
		$display("memory test done");
	endtask

	task test_host;
		reset_dut(1'b0);
		chk("inputs after reset", 32'h0, addrOe);
		chk("host mode", 32'h1, hostMode);
		apb(1'b0, {24'h0, OFF_EXT_BUS_CTRL}, 32'h0);
		chk("holder reset", 32'h1, rd);
		apb(1'b0, {24'h0, OFF_GPIO_DIR}, 32'h0);
		chk("direction reset", 32'h0, rd);
		@(posedge mclk);
		extOe <= 20'hfffff;
		extOut <= 20'h9c3a5;
		repeat (3) @(negedge mclk);
		chk("host address", 32'hc3a5, hostAddr);
		apb(1'b0, {24'h0, OFF_GPIO_IN}, 32'h0);
		chk("io input", 32'h9, rd);
		apb(1'b0, {24'h0, OFF_HOST_ADDR}, 32'h0);
		chk("host address reg", 32'hc3a5, rd);
		@(posedge mclk);
		extOe <= 20'h0ffff;
		apb(1'b1, {24'h0, OFF_GPIO_DIR}, 32'hf);
		apb(1'b1, {24'h0, OFF_GPIO_OUT}, 32'ha);
		repeat (2) @(negedge mclk);
		chk("io oe", 32'hf0000, addrOe);
		chk("io out", 32'ha, addrOut[19:16]);
		@(posedge mclk);
		hostData <= 16'h1234;
		hostCycle <= 1'b1;
		@(posedge mclk);
		hostData <= 16'hedcb;
		@(negedge mclk);
		chk("first word", 32'h11234, {wordValid, hostWord});
		@(posedge mclk);
		hostCycle <= 1'b0;
		@(negedge mclk);
		chk("second word", 32'h1edcb, {wordValid, hostWord});
		@(negedge mclk);
		chk("word idle", 32'h0, wordValid);
		apb(1'b1, 32'h40, 32'h1);
		chk("unmapped error", 32'h1, err);
		apb(1'b0, 32'h40, 32'h0);
		chk("unmapped read", 32'h0, rd);
		$display("host test done");
	endtask

	task finish_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		test_memory;
		test_host;
		finish_test;
	end

	initial begin
		repeat (3000) @(posedge mclk);
		fails++;
		finish_test;
	end
endmodule

/* File: tb/pin_partner.sv */
// Model of the board around the address pins: external host or memory drive and the pin wire itself.
// Assumes the device drive and keeper drive of the mux, and a bench that sets the external drive.
`timescale 1ns/1ps

module pin_partner import pin_mux_pkg::*; (
	input wire logic mclk,
	input wire logic [ADDR_PINS-1:0] devOut,
	input wire logic [ADDR_PINS-1:0] devOe,
	input wire logic [ADDR_PINS-1:0] keepOut,
	input wire logic [ADDR_PINS-1:0] keepOe,
	input wire logic [ADDR_PINS-1:0] extOut,
	input wire logic [ADDR_PINS-1:0] extOe,
	output logic [ADDR_PINS-1:0] pinLevel
);
	logic [ADDR_PINS-1:0] lastLevel = '0;
	logic [ADDR_PINS-1:0] freeBits;

	// Device drive wins, then the host, then the weak keeper; the host puts 16-bit addresses on pins 17 to 2.
	// A pin that nobody drives shows the inverse of its last level.
	assign freeBits = ~devOe & ~keepOe & ~extOe;
	assign pinLevel = (devOe & devOut) | (~devOe & extOe & extOut) | (~devOe & ~extOe & keepOe & keepOut)
		| (freeBits & ~lastLevel);

	always_ff @(posedge mclk) begin
		lastLevel <= pinLevel;
	end
endmodule
